/* rtl/pdbf_framer.sv */
// Land pre-pit data block framer: builds the 16 frames of a block and
// checks both parities of received blocks.
// Assumes the modulator asks for frames no faster than every other cycle
// and the detector delivers received bytes in frame order.
//
// Functional notes
// - Address bits sent as 101 or 100
// - Sixteen frames numbered 0000 to 1111
// - Relative address equals sector low nibble
// - Relative address has no check
// - Block address is inverted sector bits 23:4
// - Data zone starts at block address FFCFFF
// - Part A address; Part B typed information
// - Selector codes zero to five defined
// - Lead-in cycles selectors 1-5, then 0
// - Parity A over bytes 0 to 2
// - Parity B over bytes 6 to 12
// - Generator from three alpha roots
// - Sync code at bit position zero
// - Selector zero block layout
// - Sync code in the even slot
// - Layer byte bit 5, rest zero
`timescale 1ns/1ps
`default_nettype none

module pdbf_framer (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_start,           // Begin a block, one-cycle pulse
  input wire logic [23:0] i_psn,      // Sector number of the block's frame 0
  input wire logic i_auto_type,       // Derive selector from the address
  input wire logic [7:0] i_info_type, // Selector used when not automatic
  input wire logic i_layer,           // 0 = layer 0, 1 = layer 1
  input wire logic [47:0] i_info,     // Part B bytes 7..12, byte 7 on top
  input wire logic i_frame_req,       // Modulator takes the next frame
  input wire logic i_rx_valid,        // Received byte present
  input wire logic [3:0] i_rx_rel,    // Received relative address
  input wire logic [7:0] i_rx_byte,   // Received information byte
  output pdbf_pkg::pdbf_frame_t o_frame,
  output logic o_frame_valid,
  output logic o_busy,
  output logic o_par_a_err,
  output logic o_par_b_err,
  output logic o_rx_done
);
  import pdbf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Module state
  typedef struct packed {
    pdbf_state_t st;      // Transmit phase
    logic [3:0] idx;      // Next frame to send
    logic [23:0] addr;    // Block address of the current block
    logic [7:0] sel;      // info_type_selector of the current block
    logic layer;          // Layer of the current block
    logic [47:0] info;    // Part B bytes for selectors other than 0
    pdbf_frame_t frame;   // Frame on the output
    logic fvalid;         // Frame output strobe
    logic busy;           // Block in progress
    logic rx_mis;         // Mismatch seen in the current parity field
    logic a_err;          // Last parity A result
    logic b_err;          // Last parity B result
    logic rx_done;        // Last frame of a received block seen
  } pdbf_regs_t;

  pdbf_regs_t q;
  pdbf_regs_t d;

  pdbf_par_t tx_par; // Remainder of the transmit path
  pdbf_par_t rx_par; // Remainder of the receive path
  logic tx_shift;
  logic tx_clear;
  logic [7:0] tx_byte;
  logic rx_shift;
  logic rx_clear;
  logic [23:0] start_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // True for bytes that enter a parity remainder
  function automatic logic is_msg(input logic [3:0] i);
    return (i <= IDX_ADDR_LAST) || ((i >= IDX_TYPE) && (i <= IDX_INFO_LAST));
  endfunction

  // True for the first byte of a parity-covered part
  function automatic logic is_part_start(input logic [3:0] i);
    return (i == IDX_FIRST) || (i == IDX_TYPE);
  endfunction

  // Four address bits as pit patterns
  function automatic logic [11:0] rel_pits(input logic [3:0] r);
    logic [11:0] p;
    p = '0;
    for (int b = 0; b < 4; b++) begin
      p[b*3 +: 3] = r[b] ? PIT_ONE : PIT_ZERO;
    end
    return p;
  endfunction

  // Selector that belongs at a block address
  function automatic logic [7:0] auto_type(input logic [23:0] a);
    logic [23:0] off;
    off = ADDR_LEADIN_START - a;
    // Before lead-in, the last lead-in blocks and the data zone use 0
    if ((a > ADDR_LEADIN_START) || (a <= ADDR_TYPE0_FIRST)) begin
      return TYPE_ADDR_LAYER;
    end
    return TYPE_APP_PHYS + 8'(off % CYCLED_TYPES);
  endfunction

  // Information byte of a frame
  function automatic logic [7:0] frame_byte(input pdbf_regs_t s,
                                            input pdbf_par_t p);
    logic [3:0] k;
    k = s.idx - IDX_INFO0;
    case (s.idx)
      4'h0, 4'h1, 4'h2: begin
        return s.addr[23 - 8*s.idx -: 8];
      end
      4'h3, 4'h4, 4'h5: begin
        return par_byte(p, 2'(s.idx - IDX_PAR_A0));
      end
      4'h6: begin
        return s.sel;
      end
      4'hd, 4'he, 4'hf: begin
        return par_byte(p, 2'(s.idx - IDX_PAR_B0));
      end
      default: begin
        if (s.sel != TYPE_ADDR_LAYER) begin
          return s.info[47 - 8*k -: 8];
        end else if (s.idx < IDX_LAYER) begin
          return s.addr[23 - 8*(s.idx - IDX_INFO0) -: 8];
        end else if (s.idx == IDX_LAYER) begin
          return 8'(s.layer) << LAYER_BIT;
        end
        return ZERO_BYTE;
      end
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Parity paths
  assign start_addr = ~{4'h0, i_psn[23:4]};
  assign tx_byte = frame_byte(q, tx_par);
  assign tx_shift = (q.st == PDBF_SEND) && i_frame_req && is_msg(q.idx);
  assign tx_clear = is_part_start(q.idx);
  // The relative address never enters a remainder
  assign rx_shift = i_rx_valid && is_msg(i_rx_rel);
  assign rx_clear = is_part_start(i_rx_rel);

  // Transmit remainder
  pdbf_rs_parity u_tx_par (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_shift(tx_shift),
    .i_clear(tx_clear),
    .i_byte(tx_byte),
    .o_par(tx_par)
  );

  // Receive remainder
  pdbf_rs_parity u_rx_par (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_shift(rx_shift),
    .i_clear(rx_clear),
    .i_byte(i_rx_byte),
    .o_par(rx_par)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic mis;
    mis = 1'b0;
    d = q;
    d.fvalid = 1'b0;
    d.rx_done = 1'b0;
    // Transmit sequencer
    case (q.st)
      PDBF_IDLE: begin
        if (i_start) begin
          d.addr = start_addr;
          d.sel = i_auto_type ? auto_type(start_addr) : i_info_type;
          d.layer = i_layer;
          d.info = i_info;
          d.idx = IDX_FIRST;
          d.busy = 1'b1;
          d.st = PDBF_SEND;
        end
      end
      PDBF_SEND: begin
        if (i_frame_req) begin
          // Frame sector is the block base plus idx, so its nibble is idx
          d.frame.blk_start = (q.idx == IDX_FIRST);
          d.frame.sync_even = 1'b1;
          d.frame.rel = q.idx;
          d.frame.rel_pits = rel_pits(q.idx);
          d.frame.data = tx_byte;
          d.fvalid = 1'b1;
          if (q.idx == IDX_LAST) begin
            d.st = PDBF_IDLE;
            d.busy = 1'b0;
          end else begin
            d.idx = q.idx + 4'h1;
          end
        end
      end
      default: begin
        d.st = PDBF_IDLE;
        d.busy = 1'b0;
      end
    endcase
    // Receive checker on the parity fields
    if (i_rx_valid) begin
      case (i_rx_rel)
        4'h3, 4'h4, 4'h5: begin
          mis = i_rx_byte != par_byte(rx_par, 2'(i_rx_rel - IDX_PAR_A0));
          d.rx_mis = (i_rx_rel == IDX_PAR_A0) ? mis : (q.rx_mis | mis);
          if (i_rx_rel == IDX_PAR_A2) begin
            d.a_err = d.rx_mis;
          end
        end
        4'hd, 4'he, 4'hf: begin
          mis = i_rx_byte != par_byte(rx_par, 2'(i_rx_rel - IDX_PAR_B0));
          d.rx_mis = (i_rx_rel == IDX_PAR_B0) ? mis : (q.rx_mis | mis);
          if (i_rx_rel == IDX_LAST) begin
            d.b_err = d.rx_mis;
            d.rx_done = 1'b1;
          end
        end
        default: begin
          d.rx_mis = q.rx_mis;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign o_frame = q.frame;
  assign o_frame_valid = q.fvalid;
  assign o_busy = q.busy;
  assign o_par_a_err = q.a_err;
  assign o_par_b_err = q.b_err;
  assign o_rx_done = q.rx_done;

endmodule

`default_nettype wire

/* rtl/pdbf_pkg.sv */
// Shared constants, types and field arithmetic of the pre-pit block framer.
// Assumes a single 250 MHz clock domain; no timing counts are needed.
`default_nettype none

package pdbf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Block geometry
  localparam int FRAMES = 16;                  // Frames in one data block
  localparam int INFO_BYTES = 6;               // Part B bytes 7 to 12
  localparam logic [3:0] IDX_FIRST = 4'h0;     // First frame, address byte 0
  localparam logic [3:0] IDX_ADDR_LAST = 4'h2; // Last address byte of Part A
  localparam logic [3:0] IDX_PAR_A0 = 4'h3;    // First byte of parity A
  localparam logic [3:0] IDX_PAR_A2 = 4'h5;    // Last byte of parity A
  localparam logic [3:0] IDX_TYPE = 4'h6;      // Selector byte, starts Part B
  localparam logic [3:0] IDX_INFO0 = 4'h7;     // First disk information byte
  localparam logic [3:0] IDX_LAYER = 4'ha;     // Layer byte for selector 0
  localparam logic [3:0] IDX_INFO_LAST = 4'hc; // Last byte covered by parity B
  localparam logic [3:0] IDX_PAR_B0 = 4'hd;    // First byte of parity B
  localparam logic [3:0] IDX_LAST = 4'hf;      // Last frame of the block

  ////////////////////////////////////////////////////////////////////////////
  // Field arithmetic: low byte of field_primitive_poly x^8+x^4+x^3+x^2+1
  localparam logic [7:0] FIELD_POLY_LOW = 8'h1d;
  // Generator (x+1)(x+a)(x+a^2) = x^3 + 07 x^2 + 0e x + 08
  localparam logic [7:0] GEN_C2 = 8'h07;
  localparam logic [7:0] GEN_C1 = 8'h0e;
  localparam logic [7:0] GEN_C0 = 8'h08;

  ////////////////////////////////////////////////////////////////////////////
  // Addresses of the lead-in layout
  localparam logic [23:0] ADDR_LEADIN_START = 24'hffdbbb;
  localparam logic [23:0] ADDR_TYPE0_FIRST = 24'hffd003;
  localparam logic [23:0] ADDR_LEADIN_END = 24'hffd000;
  localparam logic [23:0] ADDR_DATA_START = 24'hffcfff;
  localparam logic [23:0] CYCLED_TYPES = 24'h000005; // Selectors 1..5

  ////////////////////////////////////////////////////////////////////////////
  // info_type_selector codes
  localparam logic [7:0] TYPE_ADDR_LAYER = 8'h00;
  localparam logic [7:0] TYPE_APP_PHYS = 8'h01;
  localparam logic [7:0] TYPE_L1_LAST = 8'h02;
  localparam logic [7:0] TYPE_MAKER_1 = 8'h03;
  localparam logic [7:0] TYPE_MAKER_2 = 8'h04;
  localparam logic [7:0] TYPE_RESERVED = 8'h05;

  // Layer byte: frame bit 5 is byte bit 7, bits 6..12 are zero
  localparam int LAYER_BIT = 7;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // Three-slot pit patterns of one relative address bit
  localparam logic [2:0] PIT_ONE = 3'b101;
  localparam logic [2:0] PIT_ZERO = 3'b100;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic {PDBF_IDLE, PDBF_SEND} pdbf_state_t;

  typedef struct packed {
    logic [7:0] r2; // Highest order parity byte
    logic [7:0] r1;
    logic [7:0] r0;
  } pdbf_par_t;

  typedef struct packed {
    logic blk_start;     // Frame 0 of a block
    logic sync_even;     // Sync code goes into the even slot of bit 0
    logic [3:0] rel;     // Relative address
    logic [11:0] rel_pits; // Four pit patterns, msb bit first
    logic [7:0] data;    // Information byte, bit 7 is frame bit 5
  } pdbf_frame_t;

  ////////////////////////////////////////////////////////////////////////////
  // Multiply two field elements
  function automatic logic [7:0] gf_mul(input logic [7:0] a,
                                        input logic [7:0] b);
    logic [7:0] acc;
    logic [7:0] sh;
    acc = 8'h00;
    sh = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) begin
        acc = acc ^ sh;
      end
      sh = sh[7] ? ({sh[6:0], 1'b0} ^ FIELD_POLY_LOW) : {sh[6:0], 1'b0};
    end
    return acc;
  endfunction

  // Pick parity byte k (0 = highest order)
  function automatic logic [7:0] par_byte(input pdbf_par_t p,
                                          input logic [1:0] k);
    case (k)
      2'd0: return p.r2;
      2'd1: return p.r1;
      default: return p.r0;
    endcase
  endfunction

endpackage

`default_nettype wire

/* rtl/pdbf_rs_parity.sv */
// Serial remainder of I(x)*x^3 modulo the degree-three generator.
// Assumes i_clear only arrives together with i_shift on a first byte.
`timescale 1ns/1ps
`default_nettype none

module pdbf_rs_parity (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_shift,      // Absorb i_byte this cycle
  input wire logic i_clear,      // Start a new remainder with this byte
  input wire logic [7:0] i_byte, // Message byte, highest order first
  output pdbf_pkg::pdbf_par_t o_par
);
  import pdbf_pkg::*;

  pdbf_par_t par_q; // Remainder register
  pdbf_par_t par_d;
  pdbf_par_t base;  // Remainder the byte is folded into
  logic [7:0] fb;   // Feedback term

  ////////////////////////////////////////////////////////////////////////////
  // Division step: one byte per shift, highest term first
  always_comb begin
    par_d = par_q;
    base = i_clear ? '0 : par_q;
    fb = i_byte ^ base.r2;
    if (i_shift) begin
      par_d.r2 = base.r1 ^ gf_mul(fb, GEN_C2);
      par_d.r1 = base.r0 ^ gf_mul(fb, GEN_C1);
      par_d.r0 = gf_mul(fb, GEN_C0);
    end
  end

  // Remainder register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      par_q <= '0;
    end else begin
      par_q <= par_d;
    end
  end

  assign o_par = par_q;

endmodule

`default_nettype wire

/* tb/pdbf_framer_props.sv */
// Checker of the framer's port behaviour.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module pdbf_framer_props (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_start,
  input wire logic i_frame_req,
  input wire logic i_rx_valid,
  input wire logic [3:0] i_rx_rel,
  input wire pdbf_pkg::pdbf_frame_t o_frame,
  input wire logic o_frame_valid,
  input wire logic o_busy,
  input wire logic o_rx_done
);
  import pdbf_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  logic [3:0] last_rel_q; // Address of the previous emitted frame
  ////////////////////////////////////////////////////////////////////////////
  // Remember the last emitted relative address
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      last_rel_q <= 4'h0;
    end else if (o_frame_valid) begin
      last_rel_q <= o_frame.rel;
    end
  end
  // Expected pit patterns of a relative address
  function automatic logic [11:0] pits(input logic [3:0] r);
    for (int b = 0; b < 4; b++) begin
      pits[3*b+:3] = r[b] ? 3'b101 : 3'b100;
    end
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Request accepted, then frame shown
  sequence s_take;
    i_frame_req && o_busy;
  endsequence
  sequence s_emit;
    o_frame_valid;
  endsequence
  chk_frame_answer: assert property (s_take |=> s_emit)
    else $error("frame missing after request");
  chk_no_spurious: assert property (
    !(i_frame_req && o_busy) |=> !o_frame_valid)
    else $error("frame without request");
  chk_busy_rise: assert property (i_start && !o_busy |=> o_busy)
    else $error("busy did not rise");
  chk_sync_even: assert property (s_emit |-> o_frame.sync_even)
    else $error("sync not in even slot");
  chk_pit_code: assert property (
    s_emit |-> o_frame.rel_pits == pits(o_frame.rel))
    else $error("wrong pit patterns");
  chk_rel_order: assert property (
    s_emit |-> (o_frame.blk_start ? o_frame.rel == 4'h0
                                  : o_frame.rel == last_rel_q + 4'h1))
    else $error("relative address out of order");
  chk_last_frame: assert property (
    s_emit and (o_frame.rel == 4'hf) |-> !o_busy)
    else $error("busy after last frame");
  chk_frame_hold: assert property (
    !o_frame_valid |-> $stable(o_frame))
    else $error("frame changed between frames");
  chk_rx_done: assert property (
    i_rx_valid && i_rx_rel == 4'hf |=> o_rx_done ##1 !o_rx_done)
    else $error("receive done pulse wrong");
endmodule
bind pdbf_framer pdbf_framer_props u_props (.i_clk, .i_arst_n, .i_start,
  .i_frame_req, .i_rx_valid, .i_rx_rel, .o_frame, .o_frame_valid, .o_busy,
  .o_rx_done);
`default_nettype wire

/* tb/pdbf_mod_model.sv */
// Modulator model: asks the framer for frames while it is busy.
// Keeps at least two cycles between requests; i_gap widens the spacing.
`timescale 1ns/1ps
`default_nettype none
module pdbf_mod_model (
  input wire logic i_clk,
  input wire logic i_busy,
  input wire logic [3:0] i_gap,
  output logic o_frame_req
);
  int cnt = 0; // Cycles still to rest before the next request
  initial o_frame_req = 1'b0;
  // One-cycle request, then rest so the parity has its spare cycle
  always @(posedge i_clk) begin
    #1;
    if (o_frame_req) begin
      o_frame_req = 1'b0;
      cnt = int'(i_gap) - 2;
    end else if (cnt > 0) begin
      cnt--;
    end else begin
      o_frame_req = i_busy;
    end
  end
endmodule
`default_nettype wire

/* tb/tb_prepit_data_block_framer.sv */
// Testbench of the pre-pit block framer: builds blocks and checks them,
// then feeds blocks back, some corrupted. Uses the modulator model.
`timescale 1ns/1ps
`default_nettype none
module tb_prepit_data_block_framer;
  import pdbf_pkg::*;
  logic clk, arst_n, start, auto_t, layer, req, rx_v, busy;
  logic a_err, b_err, rx_done, fvalid;
  logic [3:0] rx_rel, gap;
  logic [7:0] typ, rx_b;
  logic [23:0] psn;
  logic [47:0] info;
  pdbf_frame_t frame;
  pdbf_frame_t got [16]; // Frames caught this block
  logic [7:0] eb [16]; // Expected block bytes
  int num_errors, samples_checked;
  int nfr = 0; // Frames caught in the current block
  pdbf_framer dut (.i_clk(clk), .i_arst_n(arst_n), .i_start(start),
    .i_psn(psn), .i_auto_type(auto_t), .i_info_type(typ), .i_layer(layer),
    .i_info(info), .i_frame_req(req), .i_rx_valid(rx_v), .i_rx_rel(rx_rel),
    .i_rx_byte(rx_b), .o_frame(frame), .o_frame_valid(fvalid),
    .o_busy(busy), .o_par_a_err(a_err), .o_par_b_err(b_err),
    .o_rx_done(rx_done));
  pdbf_mod_model u_mod (.i_clk(clk), .i_busy(busy), .i_gap(gap),
    .o_frame_req(req));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Catch each emitted frame in order; a taken start restarts the count
  always @(posedge clk) begin
    if (start && !busy) begin
      nfr <= 0;
    end else if (fvalid) begin
      got[nfr] <= frame;
      nfr <= nfr + 1;
    end
  end
  task automatic check(input string nm, input logic [25:0] e,
                       input logic [25:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
    gm = 8'h00;
    for (int i = 0; i < 8; i++) begin
      gm = b[i] ? gm ^ a : gm;
      a = a[7] ? {a[6:0], 1'b0} ^ 8'h1d : {a[6:0], 1'b0};
    end
  endfunction
  // Remainder of bytes s..s+n-1 times x^3 by (x+1)(x+a)(x+a^2)
  function automatic logic [23:0] par(input int s, input int n);
    logic [7:0] r2, r1, r0, f;
    {r2, r1, r0} = 24'h000000;
    for (int i = s; i < s + n; i++) begin
      f = eb[i] ^ r2;
      r2 = r1 ^ gm(f, 8'h07);
      r1 = r0 ^ gm(f, 8'h0e);
      r0 = gm(f, 8'h08);
    end
    par = {r2, r1, r0};
  endfunction
  function automatic logic [11:0] pits(input logic [3:0] r);
    for (int b = 0; b < 4; b++) begin
      pits[3*b+:3] = r[b] ? 3'b101 : 3'b100;
    end
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Start one block, refuse a second start if dup, compare all frames
  task automatic run_block(input logic [23:0] p, input logic au,
    input logic [7:0] t, input logic [7:0] et, input logic ly,
    input logic [47:0] inf, input logic dup);
    int w;
    logic [23:0] a;
    logic [25:0] ef;
    {psn, auto_t, typ, layer, info, start} = {p, au, t, ly, inf, 1'b1};
    @(posedge clk);
    #1 start = 1'b0;
    psn = ~p;
    w = 0;
    while ((nfr < 16 || busy) && w < 300) begin
      @(posedge clk);
      #1 w++;
      start = dup && w == 6;
    end
    check("block end", 26'h0, {25'h0, w >= 300});
    a = {4'hf, ~p[23:4]};
    {eb[0], eb[1], eb[2], eb[6]} = {a, et};
    {eb[7], eb[8], eb[9], eb[10], eb[11], eb[12]} =
      (et == 8'h00) ? {a, ly, 7'h00, 16'h0000} : inf;
    {eb[3], eb[4], eb[5]} = par(0, 3);
    {eb[13], eb[14], eb[15]} = par(6, 7);
    for (int k = 0; k < 16; k++) begin
      ef = {k == 0, 1'b1, k[3:0], pits(k[3:0]), eb[k]};
      check("frame", ef, got[k]);
    end
  endtask
  task automatic t_data_start();
    logic [23:0] sa;
    gap = 4'h2;
    run_block(24'h030000, 1'b1, 8'h55, 8'h00, 1'b1, 48'h0, 1'b1);
    sa = {got[0].data, got[1].data, got[2].data};
    check("start address", 26'hffcfff, sa);
    check("layer byte", 26'h80, got[10].data);
    $display("test data_start done");
  endtask
  // Every selector code by hand, slow modulator
  task automatic t_types();
    gap = 4'h3;
    for (int t = 0; t < 6; t++) begin
      run_block(24'h123450, 1'b0, t[7:0], t[7:0], 1'b0,
        48'h0a1b2c3d4e5f, 1'b0);
    end
    $display("test types done");
  endtask
  // Selector derived from the block address across the lead-in
  task automatic t_auto();
    logic [23:0] ad [6] = '{24'hffdbbc, 24'hffdbbb, 24'hffdbba, 24'hffd004,
                            24'hffd003, 24'hffd000};
    logic [7:0] ex [6] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h00, 8'h00};
    gap = 4'h2;
    for (int i = 0; i < 6; i++) begin
      run_block({~ad[i][19:0], 4'h0}, 1'b1, 8'h03, ex[i], 1'b1,
        48'habcdef012345, 1'b0);
    end
    $display("test auto done");
  endtask
  // Feed the last block back, back to back, one byte damaged on every pass but the first
  task automatic t_rx();
    int bad [5] = '{-1, 1, 4, 8, 14};
    for (int j = 0; j < 5; j++) begin
      for (int k = 0; k < 16; k++) begin
        {rx_v, rx_rel} = {1'b1, k[3:0]};
        rx_b = eb[k] ^ ((k == bad[j]) ? 8'h10 : 8'h00);
        @(posedge clk);
        #1;
      end
      check("rx done", 26'h1, rx_done);
      check("parity a flag", (bad[j] == 1 || bad[j] == 4), a_err);
      check("parity b flag", (bad[j] > 7), b_err);
    end
    // Strobe stays up between blocks, dropped once after the last
    rx_v = 1'b0;
    $display("test rx done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {arst_n, start, auto_t, layer, rx_v, typ, rx_b, rx_rel, psn, info} = '0;
    {gap, num_errors, samples_checked} = '0;
    repeat (12) @(posedge clk);
    #1 arst_n = 1'b1;
    t_data_start();
    t_types();
    t_auto();
    t_rx();
    tally_and_finish();
  end
  // Watchdog: about eight times the expected run
  initial begin
    #20000;
    num_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
